/* File: logic/limit_alert_qualifier.sv */
// Overview of operation
// - Four 16-bit low-voltage thresholds, indices 40h to 43h.
// - Low-voltage thresholds compared as signed numbers.
// - Over-current run fields: channel 1 in bits 7-6.
// - Field codes mean 1, 4, 8, 16 samples.
// - All run-length fields reset to code 00.
// - Run counter changes only on completed conversions.
// - Cleared alert resets on first clean conversion.
// - Under-current run register, same fields and counting.
// - Over-power run register, same fields and counting.
// - Over-voltage run register, same fields and counting.
// - Only consecutive exceeding results count; clean breaks run.
// - Over-power compares magnitudes, either sign trips.
//
// The APB register port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
module limit_alert_qualifier (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic conv_done_in,
    input wire logic [3:0][15:0] voltage_in,
    input wire logic [3:0][15:0] current_in,
    input wire logic [3:0][23:0] power_in,
    input wire logic [3:0][15:0] over_current_limit_in,
    input wire logic [3:0][15:0] under_current_limit_in,
    input wire logic [3:0][23:0] power_threshold_in,
    input wire logic [3:0][15:0] over_voltage_limit_in,
    output logic [19:0] alert_active_out,
    output logic irq_out
);
    typedef struct packed {
        logic [3:0][15:0] uv_thr;
        logic [3:0][7:0] run_cfg;
        logic [19:0][4:0] run_cnt;
        logic [19:0] active;
        logic [19:0] status;
        logic [19:0] mask;
        logic [31:0] rdata;
    } state_t;

    state_t q_ff;
    state_t nxt_q;
    logic [19:0] exceed;
    logic [7:0] idx;
    logic aligned;
    logic setup;
    logic wr_acc;
    logic rd_acc;

    // Sample count demanded by a two-bit run-length code.
    function automatic logic [4:0] run_len(input logic [1:0] code);
        if (code == limit_alert_pkg::RUN_CODE_1) begin
            return limit_alert_pkg::RUN_LEN_1;
        end else if (code == limit_alert_pkg::RUN_CODE_4) begin
            return limit_alert_pkg::RUN_LEN_4;
        end else if (code == limit_alert_pkg::RUN_CODE_8) begin
            return limit_alert_pkg::RUN_LEN_8;
        end else begin
            return limit_alert_pkg::RUN_LEN_16;
        end
    endfunction

    // Field of one channel: channel 1 sits in the top two bits.
    function automatic logic [1:0] ch_field(input logic [7:0] cfg,
                                            input int ch);
        return cfg[(3 - ch) * 2 +: 2];
    endfunction

    // Magnitude of a 24-bit signed value, widened so -2^23 fits.
    function automatic logic [24:0] mag24(input logic [23:0] v);
        if (v[23]) begin
            return 25'(-$signed({v[23], v}));
        end else begin
            return {1'b0, v};
        end
    endfunction

    // Samples needed before an event of this kind and channel fires.
    // Low voltage has no run register of its own, so here one sample.
    function automatic logic [4:0] target(input logic [3:0][7:0] cfg,
                                          input int kind, input int ch);
        if (kind == limit_alert_pkg::KIND_UV) begin
            return limit_alert_pkg::RUN_LEN_1;
        end else begin
            return run_len(ch_field(cfg[kind], ch));
        end
    endfunction

    // Bus decode: only word-aligned addresses inside the index range map.
    assign idx = paddr_in[9:2];
    assign aligned = (paddr_in[1:0] == 2'h0) && (paddr_in[11:10] == 2'h0);
    assign setup = psel_in && !penable_in;
    assign wr_acc = psel_in && penable_in && pwrite_in;
    assign rd_acc = psel_in && penable_in && !pwrite_in;

    function automatic logic mapped(input logic [7:0] i, input logic al);
        if (!al) begin
            return 1'b0;
        end else if (i >= limit_alert_pkg::UV_THR_IDX0 &&
                     i <= limit_alert_pkg::OV_RUN_IDX) begin
            return 1'b1;
        end else if (i >= limit_alert_pkg::STATUS_IDX &&
                     i <= limit_alert_pkg::ACTIVE_IDX) begin
            return 1'b1;
        end else begin
            return 1'b0;
        end
    endfunction

    // The slave never stretches a transfer, so pready is simply high.
    assign pready_out = 1'b1;
    assign pslverr_out = psel_in && penable_in && !mapped(idx, aligned);
    assign prdata_out = q_ff.rdata;
    assign alert_active_out = q_ff.active;
    assign irq_out = |(q_ff.status & q_ff.mask);

    // Limit comparisons for every kind and channel.
    always_comb begin
        exceed = 20'h00000;
        for (int c = 0; c < limit_alert_pkg::NUM_CH; c++) begin
            exceed[limit_alert_pkg::KIND_OC * 4 + c] =
                $signed(current_in[c]) > $signed(over_current_limit_in[c]);
            exceed[limit_alert_pkg::KIND_UC * 4 + c] =
                $signed(current_in[c]) < $signed(under_current_limit_in[c]);
            exceed[limit_alert_pkg::KIND_OP * 4 + c] =
                mag24(power_in[c]) > mag24(power_threshold_in[c]);
            exceed[limit_alert_pkg::KIND_OV * 4 + c] =
                $signed(voltage_in[c]) > $signed(over_voltage_limit_in[c]);
            exceed[limit_alert_pkg::KIND_UV * 4 + c] =
                $signed(voltage_in[c]) < $signed(q_ff.uv_thr[c]);
        end
    end

    // Next state: register writes, read-to-clear, then run counting.
    // Event sets are applied after the read clear so a set always wins.
    always_comb begin
        logic [4:0] tgt;
        logic [4:0] cnt;
        int e;
        tgt = 5'h00;
        cnt = 5'h00;
        e = 0;
        nxt_q = q_ff;
        if (wr_acc && mapped(idx, aligned)) begin
            if (idx <= limit_alert_pkg::UV_THR_IDX3) begin
                nxt_q.uv_thr[idx[1:0]] = pwdata_in[15:0];
            end else if (idx <= limit_alert_pkg::OV_RUN_IDX) begin
                nxt_q.run_cfg[idx[1:0]] = pwdata_in[7:0];
            end else if (idx == limit_alert_pkg::MASK_IDX) begin
                nxt_q.mask = pwdata_in[19:0];
            end
        end
        if (rd_acc && aligned && idx == limit_alert_pkg::STATUS_IDX) begin
            // Clear only the bits returned in the setup cycle, so an event
            // that lands between setup and access is not lost unseen.
            nxt_q.status = q_ff.status & ~q_ff.rdata[19:0];
        end
        // Counters move only when a conversion completes.
        if (conv_done_in) begin
            for (int k = 0; k < limit_alert_pkg::NUM_KIND; k++) begin
                for (int c = 0; c < limit_alert_pkg::NUM_CH; c++) begin
                    e = k * 4 + c;
                    tgt = target(q_ff.run_cfg, k, c);
                    cnt = q_ff.run_cnt[e];
                    if (exceed[e]) begin
                        if (cnt < tgt) begin
                            cnt = cnt + 5'h01;
                        end
                        nxt_q.run_cnt[e] = cnt;
                        if (cnt >= tgt) begin
                            nxt_q.active[e] = 1'b1;
                            if (!q_ff.active[e]) begin
                                nxt_q.status[e] = 1'b1;
                            end
                        end
                    end else begin
                        nxt_q.run_cnt[e] = 5'h00;
                        nxt_q.active[e] = 1'b0;
                    end
                end
            end
        end
        // Read data is captured in the setup cycle and held for access.
        if (setup && !pwrite_in) begin
            nxt_q.rdata = 32'h00000000;
            if (!mapped(idx, aligned)) begin
                nxt_q.rdata = 32'h00000000;
            end else if (idx <= limit_alert_pkg::UV_THR_IDX3) begin
                nxt_q.rdata = {16'h0000, q_ff.uv_thr[idx[1:0]]};
            end else if (idx <= limit_alert_pkg::OV_RUN_IDX) begin
                nxt_q.rdata = {24'h000000, q_ff.run_cfg[idx[1:0]]};
            end else if (idx == limit_alert_pkg::STATUS_IDX) begin
                nxt_q.rdata = {12'h000, q_ff.status};
            end else if (idx == limit_alert_pkg::MASK_IDX) begin
                nxt_q.rdata = {12'h000, q_ff.mask};
            end else begin
                nxt_q.rdata = {12'h000, q_ff.active};
            end
        end
    end

    // State register with synchronous reset.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            q_ff.uv_thr <= {4{limit_alert_pkg::UV_THR_RST}};
            q_ff.run_cfg <= {4{limit_alert_pkg::RUN_CFG_RST}};
            q_ff.run_cnt <= '0;
            q_ff.active <= 20'h00000;
            q_ff.status <= 20'h00000;
            q_ff.mask <= limit_alert_pkg::MASK_RST;
            q_ff.rdata <= 32'h00000000;
        end else begin
            q_ff <= nxt_q;
        end
    end

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);

    // A write to the channel 1 threshold lands in that threshold.
    property p_uv_write;
        wr_acc && paddr_in == 12'h100
        |=> q_ff.uv_thr[0] == $past(pwdata_in[15:0]);
    endproperty
    a_uv_write: assert property (p_uv_write)
        else $error("threshold write lost");

    // A negative voltage under a positive threshold trips at once.
    property p_uv_signed;
        conv_done_in && voltage_in[0][15] && !q_ff.uv_thr[0][15]
        |=> q_ff.active[16];
    endproperty
    a_uv_signed: assert property (p_uv_signed)
        else $error("signed low-voltage compare wrong");

    // Fields leave reset at code zero.
    property p_cfg_reset;
        $fell(rst_in) |-> q_ff.run_cfg == '0;
    endproperty
    a_cfg_reset: assert property (p_cfg_reset)
        else $error("run fields not zero after reset");

    // Channel 1 over-current fires exactly when its run reaches target.
    property p_oc_run;
        $rose(q_ff.active[0])
        |-> q_ff.run_cnt[0] >= run_len($past(q_ff.run_cfg[0][7:6]))
            && $past(q_ff.run_cnt[0]) ==
               q_ff.run_cnt[0] - 5'h01;
    endproperty
    a_oc_run: assert property (p_oc_run)
        else $error("over-current fired at wrong count");

    // Without a conversion counters and alert states hold.
    property p_hold;
        !conv_done_in |=> $stable(q_ff.run_cnt) && $stable(q_ff.active);
    endproperty
    a_hold: assert property (p_hold)
        else $error("counter moved without conversion");

    // A clean conversion ends the run and the alert state.
    property p_clean;
        conv_done_in && !exceed[8] |=> q_ff.run_cnt[8] == 5'h00
            && !q_ff.active[8];
    endproperty
    a_clean: assert property (p_clean)
        else $error("clean sample did not reset alert");

    // Over-power uses magnitude: a large negative power trips.
    property p_op_mag;
        conv_done_in && q_ff.run_cfg[2][7:6] == 2'h0
            && power_in[0] == 24'h800000 && power_threshold_in[0] == 24'h000001
        |=> q_ff.active[8];
    endproperty
    a_op_mag: assert property (p_op_mag)
        else $error("negative over-power missed");

    // An exceeding sample under code 01 needs three earlier in a row.
    property p_uc_consec;
        conv_done_in && q_ff.run_cfg[1][7:6] == 2'h1 && exceed[4]
            && q_ff.run_cnt[4] == 5'h00 |=> !q_ff.active[4];
    endproperty
    a_uc_consec: assert property (p_uc_consec)
        else $error("under-current fired on a single sample");

    // Under-current channel 1 fires on the fourth sample under code 01.
    property p_uc_fire;
        conv_done_in && q_ff.run_cfg[1][7:6] == 2'h1 && exceed[4]
            && q_ff.run_cnt[4] == 5'h03 |=> q_ff.active[4];
    endproperty
    a_uc_fire: assert property (p_uc_fire)
        else $error("under-current missed its fourth sample");

    // Over-power channel 2 under code 10 is still quiet after seven.
    property p_op_count;
        conv_done_in && q_ff.run_cfg[2][5:4] == 2'h2 && exceed[9]
            && q_ff.run_cnt[9] == 5'h06 |=> !q_ff.active[9];
    endproperty
    a_op_count: assert property (p_op_count)
        else $error("over-power fired before eight samples");

    // Over-voltage channel 3 under code 11 fires on the sixteenth sample.
    property p_ov_fire;
        conv_done_in && q_ff.run_cfg[3][3:2] == 2'h3 && exceed[14]
            && q_ff.run_cnt[14] == 5'h0F
        |=> q_ff.active[14] && q_ff.run_cnt[14] == 5'h10;
    endproperty
    a_ov_fire: assert property (p_ov_fire)
        else $error("over-voltage missed its sixteenth sample");

    // Code 00 fires and latches status on one exceeding sample.
    property p_one_sample;
        conv_done_in && q_ff.run_cfg[0][1:0] == 2'h0 && exceed[3]
            && !q_ff.active[3] |=> q_ff.active[3] && q_ff.status[3];
    endproperty
    a_one_sample: assert property (p_one_sample)
        else $error("single-sample over-current missed");

    // Interrupt line stays up until status is read or mask rewritten.
    property p_irq;
        irq_out && !(psel_in && penable_in &&
            (idx == limit_alert_pkg::STATUS_IDX ||
             idx == limit_alert_pkg::MASK_IDX)) |=> irq_out;
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt dropped without status read");

    c_oc_fire: cover property ($rose(q_ff.active[0]));
    c_status_rd: cover property (rd_acc && idx == 8'h50 && irq_out);
    c_run16: cover property (q_ff.run_cnt[14] == 5'h10);
    c_uv_signed: cover property (conv_done_in && voltage_in[0][15]
        && !q_ff.uv_thr[0][15]);
    c_neg_power: cover property (conv_done_in && power_in[0][23]
        && exceed[8]);
endmodule
`default_nettype wire

/* File: logic/limit_alert_pkg.sv */
`default_nettype none
package limit_alert_pkg;
    // Register indices; the byte address on the bus is four times the index.
    localparam logic [7:0] UV_THR_IDX0 = 8'h40;
    localparam logic [7:0] UV_THR_IDX3 = 8'h43;
    localparam logic [7:0] OC_RUN_IDX = 8'h44;
    localparam logic [7:0] UC_RUN_IDX = 8'h45;
    localparam logic [7:0] OP_RUN_IDX = 8'h46;
    localparam logic [7:0] OV_RUN_IDX = 8'h47;
    localparam logic [7:0] STATUS_IDX = 8'h50;
    localparam logic [7:0] MASK_IDX = 8'h51;
    localparam logic [7:0] ACTIVE_IDX = 8'h52;
    localparam int ADDR_W = 12;
    localparam int IDX_LSB = 2;

    // Values after reset.
    localparam logic [15:0] UV_THR_RST = 16'h0000;
    localparam logic [7:0] RUN_CFG_RST = 8'h00;
    localparam logic [19:0] MASK_RST = 20'h00000;

    // Limit kinds; event bit number is kind * 4 + channel.
    localparam int KIND_OC = 0;
    localparam int KIND_UC = 1;
    localparam int KIND_OP = 2;
    localparam int KIND_OV = 3;
    localparam int KIND_UV = 4;
    localparam int NUM_KIND = 5;
    localparam int NUM_CH = 4;
    localparam int NUM_EV = 20;

    // Run-length codes of a two-bit field and their sample counts.
    localparam logic [1:0] RUN_CODE_1 = 2'h0;
    localparam logic [1:0] RUN_CODE_4 = 2'h1;
    localparam logic [1:0] RUN_CODE_8 = 2'h2;
    localparam logic [4:0] RUN_LEN_1 = 5'h01;
    localparam logic [4:0] RUN_LEN_4 = 5'h04;
    localparam logic [4:0] RUN_LEN_8 = 5'h08;
    localparam logic [4:0] RUN_LEN_16 = 5'h10;
endpackage
`default_nettype wire

/* File: tb/tb.sv */
`timescale 1ns/100ps
`default_nettype none
module tb;
    typedef struct {
        logic [31:0] d;
        logic err;
        logic irq;
        int mode;
    } exp_t;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
    logic [11:0] paddr_in = 12'h000;
    logic [31:0] pwdata_in = 32'h0;
    logic [31:0] prdata_out;
    logic pready_out, pslverr_out, irq_out;
    logic [19:0] alert_active_out;
    logic conv_done_in = 1'b0;
    logic [3:0][15:0] voltage_in = {4{16'h0032}};
    logic [3:0][15:0] current_in = '0;
    logic [3:0][23:0] power_in = '0;
    logic [3:0][15:0] over_current_limit_in = {4{16'h0064}};
    logic [3:0][15:0] under_current_limit_in = {4{16'hFF9C}};
    logic [3:0][23:0] power_threshold_in = {4{24'h000064}};
    logic [3:0][15:0] over_voltage_limit_in = {4{16'h0064}};
    int error_cnt = 0, n_tests = 0, cyc = 0;
    logic [31:0] seed = 32'h0000B05D;
    exp_t q[$];
    exp_t e;

    limit_alert_qualifier dut (.clk_in(clk_in), .rst_in(rst_in),
        .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
        .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
        .pready_out(pready_out), .pslverr_out(pslverr_out),
        .conv_done_in(conv_done_in), .voltage_in(voltage_in),
        .current_in(current_in), .power_in(power_in),
        .over_current_limit_in(over_current_limit_in),
        .under_current_limit_in(under_current_limit_in),
        .power_threshold_in(power_threshold_in),
        .over_voltage_limit_in(over_voltage_limit_in),
        .alert_active_out(alert_active_out), .irq_out(irq_out));

    // Free-running 20 MHz clock.
    always #25 clk_in = ~clk_in;

    // Fixed-seed xorshift keeps every run identical.
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [11:0] ba(input logic [7:0] idx);
        return {2'h0, idx, 2'h0};
    endfunction

    // Expected live alerts after n hits in a row; low voltage always uses 1.
    function automatic logic [31:0] exp_act(input int kind, input int n);
        int len[4] = '{4, 8, 16, 1};
        exp_act = 32'h0;
        for (int ch = 0; ch < 4; ch++) begin
            if (n >= ((kind == 4) ? 1 : len[ch])) begin
                exp_act[kind * 4 + ch] = 1'b1;
            end
        end
    endfunction

    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] expv);
        n_tests++;
        if (seen !== expv) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", name, expv, seen);
        end
    endtask

    task automatic stop_test();
        if (q.size() != 0) begin
            error_cnt++;
        end
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // One APB transfer; mode 0 write, 1 read, 2 read with irq check.
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d, input int mode,
                       input logic err, input logic irq_e);
        q.push_back('{d: d, err: err, irq: irq_e, mode: mode});
        @(posedge clk_in);
        psel_in <= 1'b1;
        penable_in <= 1'b0;
        pwrite_in <= wr;
        paddr_in <= a;
        pwdata_in <= wr ? d : xs();
        @(posedge clk_in);
        penable_in <= 1'b1;
        do @(posedge clk_in); while (pready_out !== 1'b1);
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask

    // One conversion pulse; inputs fall back to clean values after it so
    // that idle cycles must not disturb the run counters.
    task automatic conv(input int kind, input logic hit);
        logic [15:0] v;
        @(posedge clk_in);
        for (int ch = 0; ch < 4; ch++) begin
            v = 16'h0065 + 16'(xs() & 32'h000003FF);
            if (hit) begin
                case (kind)
                    0: current_in[ch] <= v;
                    1: current_in[ch] <= -v;
                    2: power_in[ch] <= seed[0] ? {8'h00, v} : -{8'h00, v};
                    3: voltage_in[ch] <= v;
                    5: power_in[ch] <= 24'h800000;
                    default: voltage_in[ch] <= -v;
                endcase
            end
        end
        conv_done_in <= 1'b1;
        @(posedge clk_in);
        conv_done_in <= 1'b0;
        voltage_in <= {4{16'h0032}};
        current_in <= '0;
        power_in <= '0;
    endtask

    // Result monitor: each completed access retires the oldest note.
    always @(posedge clk_in) begin
        if (psel_in && penable_in && pready_out === 1'b1 && q.size() > 0) begin
            e = q.pop_front();
            check("pslverr", {31'h0, pslverr_out}, {31'h0, e.err});
            if (e.mode > 0) begin
                check("prdata", prdata_out, e.d);
            end
            if (e.mode > 1) begin
                check("irq", {31'h0, irq_out}, {31'h0, e.irq});
            end
        end
    end

    // Hang guard, well above the roughly 640 cycles the tests need.
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            stop_test();
        end
    end

    initial begin
        logic [31:0] w;
        repeat (5) @(posedge clk_in);
        rst_in <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            apb(1'b0, ba(8'h40 + i[7:0]), 32'h0, 1, 1'b0, 1'b0);
        end
        apb(1'b0, ba(limit_alert_pkg::MASK_IDX), 32'h0, 1, 1'b0, 1'b0);
        apb(1'b0, ba(limit_alert_pkg::STATUS_IDX), 32'h0, 2, 1'b0, 1'b0);
        $display("test reset_values done");
        for (int i = 0; i < 8; i++) begin
            w = xs();
            w = (i < 4) ? {16'h0, w[15:0]} : {24'h0, w[7:0]};
            apb(1'b1, ba(8'h40 + i[7:0]), w, 0, 1'b0, 1'b0);
            apb(1'b0, ba(8'h40 + i[7:0]), w, 1, 1'b0, 1'b0);
        end
        apb(1'b1, ba(8'h60), 32'hFFFFFFFF, 0, 1'b1, 1'b0);
        apb(1'b0, ba(8'h60), 32'h0, 1, 1'b1, 1'b0);
        apb(1'b0, 12'h101, 32'h0, 1, 1'b1, 1'b0);
        $display("test register_access done");
        // Thresholds of -100 against a clean level of +50 trip only if
        // the compare were unsigned. Alerts stay masked while set up.
        apb(1'b1, ba(limit_alert_pkg::MASK_IDX), 32'h0, 0, 1'b0,
            1'b0);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, ba(8'h40 + i[7:0]), 32'h0000FF9C, 0, 1'b0, 1'b0);
            apb(1'b1, ba(8'h44 + i[7:0]), 32'h0000006C, 0, 1'b0, 1'b0);
        end
        apb(1'b1, ba(limit_alert_pkg::MASK_IDX), 32'h0000F0F0, 0, 1'b0, 1'b0);
        // A clean conversion after unmasking stands in for the refresh.
        for (int k = 0; k < 5; k++) begin
            conv(k, 1'b0);
            apb(1'b0, ba(limit_alert_pkg::ACTIVE_IDX), 32'h0, 1, 1'b0,
                1'b0);
            for (int n = 1; n <= 16; n++) begin
                conv(k, 1'b1);
                apb(1'b0, ba(limit_alert_pkg::ACTIVE_IDX), exp_act(k, n), 1,
                    1'b0, 1'b0);
            end
            apb(1'b0, ba(limit_alert_pkg::STATUS_IDX), 32'hF << (k * 4), 2,
                1'b0, (k == 1 || k == 3));
            apb(1'b0, ba(limit_alert_pkg::STATUS_IDX), 32'h0, 2, 1'b0, 1'b0);
            apb(1'b0, ba(limit_alert_pkg::ACTIVE_IDX), exp_act(k, 16), 1,
                1'b0, 1'b0);
            $display("test run_length kind %0d done", k);
        end
        conv(0, 1'b0);
        repeat (3) conv(0, 1'b1);
        conv(0, 1'b0);
        repeat (3) conv(0, 1'b1);
        apb(1'b0, ba(limit_alert_pkg::ACTIVE_IDX), exp_act(0, 3), 1, 1'b0,
            1'b0);
        $display("test broken_run done");
        // A reset in mid-run must bring every run field back to code 00.
        rst_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        rst_in <= 1'b0;
        for (int i = 4; i < 8; i++) begin
            apb(1'b0, ba(8'h40 + i[7:0]), 32'h0, 1, 1'b0, 1'b0);
        end
        conv(0, 1'b1);
        apb(1'b0, ba(limit_alert_pkg::ACTIVE_IDX), 32'h0000000F, 1, 1'b0,
            1'b0);
        // Negative voltage against the zero threshold left by reset.
        conv(4, 1'b1);
        apb(1'b0, ba(limit_alert_pkg::ACTIVE_IDX), 32'h000F0000, 1, 1'b0,
            1'b0);
        // Most negative power must trip even a tiny positive limit.
        power_threshold_in[0] <= 24'h000001;
        conv(5, 1'b1);
        apb(1'b0, ba(limit_alert_pkg::ACTIVE_IDX), 32'h00000F00, 1, 1'b0,
            1'b0);
        $display("test reset_in_run done");
        // Let the monitor retire the last note before the verdict.
        repeat (2) @(posedge clk_in);
        stop_test();
    end
endmodule
`default_nettype wire
